/* File: core/ucrl_map.svh */
// Register offsets, field positions, reset values for the channel map
`ifndef UCRL_MAP_SVH
`define UCRL_MAP_SVH

// ----------------------------------------
// Offsets on the three address lines
// ----------------------------------------
`define UCRL_A_HOLD   3'h0
`define UCRL_A_IEN    3'h1
`define UCRL_A_IST    3'h2
`define UCRL_A_LCT    3'h3
`define UCRL_A_MCT    3'h4
`define UCRL_A_LST    3'h5
`define UCRL_A_MST    3'h6
`define UCRL_A_SCR    3'h7

// ----------------------------------------
// Field positions and key values
// ----------------------------------------
`define UCRL_LCT_ENH      8'hbf
`define UCRL_LCT_DIV      7
`define UCRL_ENF_ENH      4
`define UCRL_ENF_ACTS     7
`define UCRL_ENF_ARTS     6
`define UCRL_MCT_IR       6
`define UCRL_MCT_LOOP     4
`define UCRL_MCT_GO2      3
`define UCRL_MCT_GO1      2
`define UCRL_MCT_RTS      1
`define UCRL_MCT_DTR      0
`define UCRL_IST_ENH_MASK 8'hcf
`define UCRL_FCT_ENH_MASK 8'hcf
`define UCRL_DVF_MASK     8'h3f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UCRL_RST_BYTE     8'h00
`define UCRL_RST_SYNC     25'h1ffffff

`endif

/* File: core/ucrl_pkg.sv */
// Types shared by the channel register map
`default_nettype none
package ucrl_pkg;
  typedef logic [7:0] ucrl_byte_t;
  typedef logic [1:0][7:0] ucrl_bytes_t;
  typedef logic [1:0][15:0] ucrl_words_t;
  typedef logic [1:0][31:0] ucrl_quads_t;
  typedef logic [1:0][3:0] ucrl_nibs_t;
  typedef enum logic [4:0] {
    UCRL_NONE, UCRL_HOLD, UCRL_IEN, UCRL_IST, UCRL_LCT, UCRL_MCT,
    UCRL_LST, UCRL_MST, UCRL_SCR, UCRL_DVL, UCRL_DVH, UCRL_DVF,
    UCRL_REV, UCRL_ID, UCRL_ENF, UCRL_XON1, UCRL_XON2, UCRL_XOFF1,
    UCRL_XOFF2
  } ucrl_sel_t;
endpackage
`default_nettype wire

/* File: core/ucrl_regmap.sv */
// Dual channel register decode with diagnostic loopback
`timescale 1ns/1ps
`default_nettype none
`include "ucrl_map.svh"

// Overview of operation
// - Modem control bit 4 set enters loopback, cleared leaves it.
// - Loopback changes pin routing and turns off automatic flow control; other functions run unchanged.
// - In loopback the transmit serial output feeds the receiver input.
// - In loopback serial out, request and ready pins stay at idle.
// - In loopback the four external modem inputs are ignored.
// - Automatic request/clear flow control is off during loopback.
// - Each channel has own registers, picked by its select and address.
// - Address 0 with divisor bit clear reads receive, writes transmit byte.
// - Divisor bit set and no enhanced key: addresses 0, 1 are divisor.
// - Fraction divisor at address 2 needs divisor bit, no key, enable.
// - Zero divisor reads at addresses 0, 1 return revision and id.
// - Address 1 with divisor bit clear is the interrupt enable byte.
// - Without key, address 2 reads status and writes FIFO control.
// - Line control sits at address 3, modem control at address 4.
// - Without key, address 5 is line status, 6 is modem status.
// - Address 7 is a scratch byte with no hardware effect.
// - With key, address 2 is enhanced byte, 4 to 7 flow characters.
// - Enhanced upper bits change only while enhanced enable bit is set.
// - Modem control bit 6 enables infrared, bit 2 inverts its input.
module ucrl_regmap #(
  parameter ucrl_pkg::ucrl_byte_t REV_CODE = 8'h01, // Arbitrary value
  parameter ucrl_pkg::ucrl_byte_t ID_CODE  = 8'h5a  // Arbitrary value
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  chan_a_select_n,
  input  wire logic                  chan_b_select_n,
  input  wire logic                  read_n,
  input  wire logic                  write_n,
  input  wire logic [2:0]            addr,
  input  wire logic [7:0]            data_in,
  output var  logic [7:0]            data_out,
  output var  logic                  data_oe,
  input  wire ucrl_pkg::ucrl_bytes_t rx_holding,
  input  wire ucrl_pkg::ucrl_bytes_t intr_status,
  input  wire ucrl_pkg::ucrl_bytes_t line_status,
  input  wire ucrl_pkg::ucrl_bytes_t modem_status,
  output var  logic [1:0]            rx_pop,
  output var  logic [1:0]            tx_push,
  output var  ucrl_pkg::ucrl_byte_t  tx_holding,
  output var  logic [1:0]            fifo_write,
  output var  ucrl_pkg::ucrl_byte_t  fifo_control,
  output var  logic [1:0]            intr_status_read,
  output var  logic [1:0]            line_status_read,
  output var  logic [1:0]            modem_status_read,
  output var  ucrl_pkg::ucrl_bytes_t line_control,
  output var  ucrl_pkg::ucrl_bytes_t intr_enable,
  output var  ucrl_pkg::ucrl_bytes_t modem_control,
  output var  ucrl_pkg::ucrl_bytes_t enhanced_features,
  output var  ucrl_pkg::ucrl_words_t baud_divisor,
  output var  ucrl_pkg::ucrl_bytes_t baud_div_fraction,
  output var  ucrl_pkg::ucrl_quads_t flow_chars,
  output var  logic [1:0]            loopback,
  output var  logic [1:0]            ir_enable,
  output var  logic [1:0]            ir_invert,
  output var  logic [1:0]            auto_cts_enable,
  output var  logic [1:0]            auto_rts_enable,
  input  wire logic [1:0]            tx_shift_out,
  output var  logic [1:0]            rx_shift_in,
  output var  logic [1:0]            tx_pin,
  output var  logic [1:0]            rts_pin_n,
  output var  logic [1:0]            dtr_pin_n,
  output var  logic [1:0]            general_out_one_n,
  output var  logic [1:0]            general_out_two_n,
  input  wire logic [1:0]            rx_pin,
  input  wire logic [1:0]            cts_pin_n,
  input  wire logic [1:0]            dsr_pin_n,
  input  wire logic [1:0]            cd_pin_n,
  input  wire logic [1:0]            ri_pin_n,
  output var  ucrl_pkg::ucrl_nibs_t  modem_lines
);
  import ucrl_pkg::*;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  // Shared by the read and write paths; only reads see the id codes
  function automatic ucrl_sel_t decode(
    input logic [2:0] a,
    input ucrl_byte_t lct,
    input logic       enh,
    input logic       dzero,
    input logic       is_wr
  );
    logic key;
    logic dv;
    key = (lct == `UCRL_LCT_ENH);
    dv  = lct[`UCRL_LCT_DIV] & ~key;
    decode = UCRL_NONE;
    unique case (a)
      `UCRL_A_HOLD: begin
        if (!lct[`UCRL_LCT_DIV])
          decode = UCRL_HOLD;
        else if (dv && dzero && !is_wr)
          decode = UCRL_REV;
        else if (dv)
          decode = UCRL_DVL;
      end
      `UCRL_A_IEN: begin
        if (!lct[`UCRL_LCT_DIV])
          decode = UCRL_IEN;
        else if (dv && dzero && !is_wr)
          decode = UCRL_ID;
        else if (dv)
          decode = UCRL_DVH;
      end
      `UCRL_A_IST: begin
        if (key)
          decode = UCRL_ENF;
        else if (dv && enh)
          decode = UCRL_DVF;
        else
          decode = UCRL_IST;
      end
      `UCRL_A_LCT: decode = UCRL_LCT;
      `UCRL_A_MCT: decode = key ? UCRL_XON1 : UCRL_MCT;
      `UCRL_A_LST: decode = key ? UCRL_XON2 : UCRL_LST;
      `UCRL_A_MST: decode = key ? UCRL_XOFF1 : UCRL_MST;
      `UCRL_A_SCR: decode = key ? UCRL_XOFF2 : UCRL_SCR;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Bus and modem pins arrive with no relation to clk
  logic [24:0] sync_a;
  logic [24:0] sync_b;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a <= `UCRL_RST_SYNC;
      sync_b <= `UCRL_RST_SYNC;
    end else begin
      sync_a <= {chan_a_select_n, chan_b_select_n, read_n, write_n,
                 addr, data_in, rx_pin, cts_pin_n, dsr_pin_n,
                 cd_pin_n, ri_pin_n};
      sync_b <= sync_a;
    end
  end

  logic       cha_s;
  logic       chb_s;
  logic       rd_s;
  logic       wr_s;
  logic [2:0] addr_s;
  logic [7:0] din_s;
  logic [1:0] rx_s;
  logic [1:0] cts_s;
  logic [1:0] dsr_s;
  logic [1:0] cd_s;
  logic [1:0] ri_s;

  assign {cha_s, chb_s, rd_s, wr_s, addr_s, din_s, rx_s,
          cts_s, dsr_s, cd_s, ri_s} = sync_b;

  // ----------------------------------------
  // Strobe tracking
  // ----------------------------------------
  // Channel A wins if the host selects both at once
  logic       sel_any;
  logic       sel_ch;
  logic       rd_act;
  logic       wr_act;
  logic       rd_act_q;
  logic       wr_act_q;
  logic       wr_ch;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic       rd_ch;
  ucrl_sel_t  rd_sel_l;
  logic       wr_commit;
  logic       rd_done;

  assign sel_any   = ~cha_s | ~chb_s;
  assign sel_ch    = cha_s;
  assign rd_act    = sel_any & ~rd_s;
  assign wr_act    = sel_any & ~wr_s;
  assign wr_commit = wr_act_q & ~wr_act;
  assign rd_done   = rd_act_q & ~rd_act;

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  // Latch while the strobe is low: data may vanish as it rises
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ch   <= 1'b0;
      wr_addr <= 3'h0;
      wr_data <= `UCRL_RST_BYTE;
    end else if (wr_act) begin
      wr_ch   <= sel_ch;
      wr_addr <= addr_s;
      wr_data <= din_s;
    end
  end

  // ----------------------------------------
  // Per-channel register sets
  // ----------------------------------------
  ucrl_bytes_t scr;
  logic [1:0]  enh;
  logic [1:0]  dzero;
  ucrl_sel_t   wsel [2];

  for (genvar g = 0; g < 2; g++) begin : g_ch
    logic hit;

    assign enh[g]   = enhanced_features[g][`UCRL_ENF_ENH];
    assign dzero[g] = (baud_divisor[g] == 16'h0000);
    assign wsel[g]  = decode(wr_addr, line_control[g], enh[g],
                             dzero[g], 1'b1);
    assign hit      = wr_commit & (wr_ch == g[0]);

    always_ff @(posedge clk) begin
      if (rst) begin
        line_control[g]      <= `UCRL_RST_BYTE;
        intr_enable[g]       <= `UCRL_RST_BYTE;
        modem_control[g]     <= `UCRL_RST_BYTE;
        enhanced_features[g] <= `UCRL_RST_BYTE;
        baud_divisor[g]      <= 16'h0000;
        baud_div_fraction[g] <= `UCRL_RST_BYTE;
        flow_chars[g]        <= 32'h0000_0000;
        scr[g]               <= `UCRL_RST_BYTE;
      end else if (hit) begin
        unique case (wsel[g])
          UCRL_LCT: line_control[g] <= wr_data;
          UCRL_IEN: intr_enable[g] <= enh[g] ? wr_data :
            {intr_enable[g][7:4], wr_data[3:0]};
          UCRL_MCT: modem_control[g] <= enh[g] ? wr_data :
            {modem_control[g][7:5], wr_data[4:0]};
          UCRL_ENF: enhanced_features[g] <= wr_data;
          UCRL_DVL: baud_divisor[g][7:0] <= wr_data;
          UCRL_DVH: baud_divisor[g][15:8] <= wr_data;
          UCRL_DVF: baud_div_fraction[g] <= wr_data & `UCRL_DVF_MASK;
          UCRL_XON1: flow_chars[g][7:0] <= wr_data;
          UCRL_XON2: flow_chars[g][15:8] <= wr_data;
          UCRL_XOFF1: flow_chars[g][23:16] <= wr_data;
          UCRL_XOFF2: flow_chars[g][31:24] <= wr_data;
          UCRL_SCR: scr[g] <= wr_data;
          default: ; // Read-only slots ignore writes
        endcase
      end
    end

    // Write side effects, one pulse per committed write
    always_ff @(posedge clk) begin
      if (rst) begin
        tx_push[g]    <= 1'b0;
        fifo_write[g] <= 1'b0;
      end else begin
        tx_push[g]    <= hit && wsel[g] == UCRL_HOLD;
        fifo_write[g] <= hit && wsel[g] == UCRL_IST;
      end
    end

    // ----------------------------------------
    // Loopback and modem pins
    // ----------------------------------------
    logic lb;
    logic ir;
    assign lb = modem_control[g][`UCRL_MCT_LOOP];
    assign ir = modem_control[g][`UCRL_MCT_IR];

    always_ff @(posedge clk) begin
      if (rst) begin
        loopback[g]          <= 1'b0;
        ir_enable[g]         <= 1'b0;
        ir_invert[g]         <= 1'b0;
        auto_cts_enable[g]   <= 1'b0;
        auto_rts_enable[g]   <= 1'b0;
      end else begin
        loopback[g]        <= lb;
        ir_enable[g]       <= ir;
        ir_invert[g]       <= ir & modem_control[g][`UCRL_MCT_GO1];
        auto_cts_enable[g] <= ~lb &
          enhanced_features[g][`UCRL_ENF_ACTS];
        auto_rts_enable[g] <= ~lb &
          enhanced_features[g][`UCRL_ENF_ARTS];
      end
    end

    // Normal functions see only the rerouted lines, nothing else
    always_ff @(posedge clk) begin
      if (rst) begin
        rx_shift_in[g]       <= 1'b1;
        tx_pin[g]            <= 1'b1;
        rts_pin_n[g]         <= 1'b1;
        dtr_pin_n[g]         <= 1'b1;
        general_out_one_n[g] <= 1'b1;
        general_out_two_n[g] <= 1'b1;
      end else begin
        // Receive pin still read for infrared inversion outside loopback
        rx_shift_in[g] <= lb ? tx_shift_out[g] :
          rx_s[g] ^ (ir & modem_control[g][`UCRL_MCT_GO1]);
        // Idle level is low in infrared mode, mark otherwise
        tx_pin[g] <= lb ? ~ir : tx_shift_out[g];
        rts_pin_n[g] <= lb | ~modem_control[g][`UCRL_MCT_RTS];
        dtr_pin_n[g] <= lb | ~modem_control[g][`UCRL_MCT_DTR];
        general_out_one_n[g] <= lb | ~modem_control[g][`UCRL_MCT_GO1];
        general_out_two_n[g] <= lb | ~modem_control[g][`UCRL_MCT_GO2];
      end
    end

    // Order: carrier, ring, set ready, clear to send (active high)
    always_ff @(posedge clk) begin
      if (rst) begin
        modem_lines[g] <= 4'h0;
      end else if (lb) begin
        modem_lines[g] <= {modem_control[g][`UCRL_MCT_GO2],
                           modem_control[g][`UCRL_MCT_GO1],
                           modem_control[g][`UCRL_MCT_DTR],
                           modem_control[g][`UCRL_MCT_RTS]};
      end else begin
        modem_lines[g] <= ~{cd_s[g], ri_s[g], dsr_s[g], cts_s[g]};
      end
    end
  end

  // ----------------------------------------
  // Shared write data toward the FIFOs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_holding   <= `UCRL_RST_BYTE;
      fifo_control <= `UCRL_RST_BYTE;
    end else if (wr_commit) begin
      tx_holding   <= wr_data;
      fifo_control <= enh[wr_ch] ? wr_data :
        (wr_data & `UCRL_FCT_ENH_MASK);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  ucrl_sel_t  rsel;
  logic [7:0] rmux;

  assign rsel = decode(addr_s, line_control[sel_ch], enh[sel_ch],
                       dzero[sel_ch], 1'b0);

  always_comb begin
    unique case (rsel)
      UCRL_HOLD: rmux = rx_holding[sel_ch];
      UCRL_IEN: rmux = intr_enable[sel_ch];
      UCRL_IST: rmux = enh[sel_ch] ? intr_status[sel_ch] :
        (intr_status[sel_ch] & `UCRL_IST_ENH_MASK);
      UCRL_LCT: rmux = line_control[sel_ch];
      UCRL_MCT: rmux = modem_control[sel_ch];
      UCRL_LST: rmux = line_status[sel_ch];
      UCRL_MST: rmux = modem_status[sel_ch];
      UCRL_SCR: rmux = scr[sel_ch];
      UCRL_DVL: rmux = baud_divisor[sel_ch][7:0];
      UCRL_DVH: rmux = baud_divisor[sel_ch][15:8];
      UCRL_DVF: rmux = baud_div_fraction[sel_ch];
      UCRL_REV: rmux = REV_CODE;
      UCRL_ID: rmux = ID_CODE;
      UCRL_ENF: rmux = enhanced_features[sel_ch];
      UCRL_XON1: rmux = flow_chars[sel_ch][7:0];
      UCRL_XON2: rmux = flow_chars[sel_ch][15:8];
      UCRL_XOFF1: rmux = flow_chars[sel_ch][23:16];
      UCRL_XOFF2: rmux = flow_chars[sel_ch][31:24];
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
      rd_ch    <= 1'b0;
      rd_sel_l <= UCRL_NONE;
    end else begin
      data_oe <= rd_act;
      if (rd_act) begin
        data_out <= rmux;
        rd_ch    <= sel_ch;
        rd_sel_l <= rsel;
      end
    end
  end

  // Read side effects fire once, as the strobe ends
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_pop            <= 2'b00;
      intr_status_read  <= 2'b00;
      line_status_read  <= 2'b00;
      modem_status_read <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        rx_pop[c] <= rd_done && rd_ch == c[0] && rd_sel_l == UCRL_HOLD;
        intr_status_read[c] <= rd_done && rd_ch == c[0] &&
                               rd_sel_l == UCRL_IST;
        line_status_read[c] <= rd_done && rd_ch == c[0] &&
                               rd_sel_l == UCRL_LST;
        modem_status_read[c] <= rd_done && rd_ch == c[0] &&
                                rd_sel_l == UCRL_MST;
      end
    end
  end

endmodule // ucrl_regmap

`default_nettype wire

/* File: verif/ucrl_regmap_assertions.sv */
// Port-level checker for the channel register map, channel A side
`timescale 1ns/1ps
`default_nettype none
module ucrl_regmap_chk
  import ucrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        chan_a_select_n,
  input wire logic        chan_b_select_n,
  input wire logic        read_n,
  input wire logic        data_oe,
  input wire logic [1:0]  tx_push,
  input wire logic [1:0]  rx_pop,
  input wire ucrl_bytes_t line_control,
  input wire ucrl_bytes_t modem_control,
  input wire logic [1:0]  loopback,
  input wire logic [1:0]  ir_enable,
  input wire logic [1:0]  auto_cts_enable,
  input wire logic [1:0]  auto_rts_enable,
  input wire logic [1:0]  tx_shift_out,
  input wire logic [1:0]  rx_shift_in,
  input wire logic [1:0]  tx_pin,
  input wire logic [1:0]  rts_pin_n,
  input wire logic [1:0]  dtr_pin_n,
  input wire ucrl_nibs_t  modem_lines
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ucrl_byte_t mc_q;
  // Modem control as the registered pins saw it
  always_ff @(posedge clk) mc_q <= modem_control[0];

  a_loop_enter: assert property (modem_control[0][4] |-> ##[0:1] loopback[0])
    else $error("loopback does not follow modem control bit 4");
  a_loop_pins_held: assert property (loopback[0] |-> rts_pin_n[0] && dtr_pin_n[0])
    else $error("request or ready pin driven in loopback");
  a_loop_tx_idle: assert property (loopback[0] |-> tx_pin[0] == !ir_enable[0])
    else $error("serial output not idle in loopback");
  a_loop_serial: assert property (loopback[0] |-> rx_shift_in[0] == $past(tx_shift_out[0]))
    else $error("receiver input not fed from transmitter");
  a_loop_modem: assert property (loopback[0] |->
    modem_lines[0] == {mc_q[3], mc_q[2], mc_q[0], mc_q[1]})
    else $error("modem lines not returned from outputs");
  a_auto_flow_off: assert property (loopback[0] |->
    !auto_rts_enable[0] && !auto_cts_enable[0])
    else $error("auto flow control active in loopback");
  a_push_bank: assert property (tx_push[0] |-> !line_control[0][7])
    else $error("transmit push with divisor bank open");
  a_pop_single: assert property (rx_pop[0] |=> !rx_pop[0])
    else $error("receive pop longer than one cycle");
  a_read_drive: assert property ((!read_n && !(chan_a_select_n && chan_b_select_n)) [*4]
    |-> data_oe)
    else $error("selected read not driven");
  a_idle_quiet: assert property (read_n [*5] |-> !data_oe)
    else $error("data bus driven without read");
endmodule // ucrl_regmap_chk

bind ucrl_regmap ucrl_regmap_chk i_chk (
  .clk(clk), .rst(rst), .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
  .read_n(read_n), .data_oe(data_oe), .tx_push(tx_push), .rx_pop(rx_pop),
  .line_control(line_control), .modem_control(modem_control), .loopback(loopback),
  .ir_enable(ir_enable), .auto_cts_enable(auto_cts_enable), .auto_rts_enable(auto_rts_enable),
  .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in), .tx_pin(tx_pin),
  .rts_pin_n(rts_pin_n), .dtr_pin_n(dtr_pin_n), .modem_lines(modem_lines)
);
`default_nettype wire

/* File: verif/ucrl_host.sv */
// Host processor model on the asynchronous parallel register bus
`timescale 1ns/1ps
`default_nettype none
module ucrl_host (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  output var  logic       chan_a_select_n,
  output var  logic       chan_b_select_n,
  output var  logic       read_n,
  output var  logic       write_n,
  output var  logic [2:0] addr,
  output var  logic [7:0] data_in
);
  initial begin
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    read_n          = 1'b1;
    write_n         = 1'b1;
    addr            = 3'h0;
    data_in         = 8'h00;
  end

  // Write strobe stays low 4 edges, read strobe 5, both high 5, over the 3-cycle minimum
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    chan_a_select_n <= ch;
    chan_b_select_n <= !ch;
    addr            <= a;
    data_in         <= d;
    write_n         <= 1'b0;
    repeat (4) @(posedge clk);
    write_n         <= 1'b1;
    chan_a_select_n <= 1'b1;
    chan_b_select_n <= 1'b1;
    repeat (5) @(posedge clk);
    // Released bus shows no stale value
    data_in         <= ~d;
    addr            <= ~a;
  endtask

  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    chan_a_select_n <= ch;
    chan_b_select_n <= !ch;
    addr            <= a;
    read_n          <= 1'b0;
    repeat (5) @(posedge clk);
    d = data_out;
    read_n          <= 1'b1;
    chan_a_select_n <= 1'b1;
    chan_b_select_n <= 1'b1;
    repeat (5) @(posedge clk);
    addr            <= ~a;
  endtask
endmodule // ucrl_host
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the channel register map
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ucrl_pkg::*;
  localparam ucrl_byte_t REV = 8'h3c; // Arbitrary value
  localparam ucrl_byte_t IDC = 8'hc3; // Arbitrary value
  logic        clk, rst, chan_a_select_n, chan_b_select_n, read_n, write_n;
  logic [2:0]  addr;
  logic [7:0]  data_in, data_out, tx_holding, fifo_control;
  ucrl_bytes_t rx_holding, intr_status, line_status, modem_status, baud_div_fraction;
  ucrl_words_t baud_divisor;
  ucrl_quads_t flow_chars;
  ucrl_nibs_t  modem_lines;
  logic [1:0]  tx_push, rx_pop, fifo_write, loopback, ir_enable, ir_invert, auto_cts_enable;
  logic [1:0]  tx_shift_out, rx_shift_in, tx_pin, rts_pin_n, rx_pin;
  logic [1:0]  cts_pin_n, dsr_pin_n, cd_pin_n, ri_pin_n;
  int          errors, total_checks, n_push, n_pop, n_fifo, p, q;
  logic [7:0]  v;

  ucrl_regmap #(.REV_CODE(REV), .ID_CODE(IDC)) i_ucrl_regmap (
    .clk(clk), .rst(rst), .chan_a_select_n(chan_a_select_n), .chan_b_select_n(chan_b_select_n),
    .read_n(read_n), .write_n(write_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(), .rx_holding(rx_holding), .intr_status(intr_status), .line_status(line_status),
    .modem_status(modem_status), .rx_pop(rx_pop), .tx_push(tx_push), .tx_holding(tx_holding),
    .fifo_write(fifo_write), .fifo_control(fifo_control), .intr_status_read(),
    .line_status_read(), .modem_status_read(), .line_control(), .intr_enable(),
    .modem_control(), .enhanced_features(), .baud_divisor(baud_divisor),
    .baud_div_fraction(baud_div_fraction), .flow_chars(flow_chars), .loopback(loopback),
    .ir_enable(ir_enable), .ir_invert(ir_invert), .auto_cts_enable(auto_cts_enable),
    .auto_rts_enable(), .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in),
    .tx_pin(tx_pin), .rts_pin_n(rts_pin_n), .dtr_pin_n(), .general_out_one_n(),
    .general_out_two_n(), .rx_pin(rx_pin), .cts_pin_n(cts_pin_n), .dsr_pin_n(dsr_pin_n),
    .cd_pin_n(cd_pin_n), .ri_pin_n(ri_pin_n), .modem_lines(modem_lines)
  );
  ucrl_host i_ucrl_host (
    .clk(clk), .data_out(data_out), .chan_a_select_n(chan_a_select_n),
    .chan_b_select_n(chan_b_select_n), .read_n(read_n), .write_n(write_n),
    .addr(addr), .data_in(data_in)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Channel A side-effect pulses
  always @(posedge clk) begin
    if (tx_push[0] === 1'b1) n_push++;
    if (rx_pop[0] === 1'b1) n_pop++;
    if (fifo_write[0] === 1'b1) n_fifo++;
  end

  // ----------------------------------------
  // Compare and bus helpers
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    i_ucrl_host.wr(ch, a, d);
  endtask

  task automatic rchk(input logic ch, input logic [2:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    i_ucrl_host.rd(ch, a, d);
    chk(n, e, d);
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_chan;
    wr(0, 3'h7, 8'ha5);
    wr(1, 3'h7, 8'h3c);
    rchk(0, 3'h7, 8'ha5, "scratch a");
    rchk(1, 3'h7, 8'h3c, "scratch b");
    wr(1, 3'h3, 8'h1b);
    rchk(1, 3'h3, 8'h1b, "line control b");
    rchk(0, 3'h3, 8'h00, "line control a");
    wr(1, 3'h3, 8'h00);
  endtask

  task automatic t_hold;
    p = n_push;
    q = n_pop;
    wr(0, 3'h0, 8'h5e);
    chk("tx holding", 8'h5e, tx_holding);
    chk_bit("tx push once", 1'b1, n_push == p + 1);
    rchk(0, 3'h0, 8'h77, "rx holding");
    chk_bit("rx pop once", 1'b1, n_pop == q + 1);
    wr(0, 3'h1, 8'hff);
    rchk(0, 3'h1, 8'h0f, "intr enable locked");
    wr(0, 3'h4, 8'h40);
    rchk(0, 3'h4, 8'h00, "modem control locked");
    p = n_fifo;
    wr(0, 3'h2, 8'h37);
    chk("fifo control", 8'h07, fifo_control);
    chk_bit("fifo write once", 1'b1, n_fifo == p + 1);
    rchk(0, 3'h2, 8'hc1, "intr status");
    rchk(0, 3'h5, 8'h60, "line status");
    rchk(0, 3'h6, 8'h0f, "modem status");
  endtask

  task automatic t_div;
    wr(0, 3'h3, 8'h80);
    wr(0, 3'h0, 8'h12);
    wr(0, 3'h1, 8'h34);
    rchk(0, 3'h0, 8'h12, "divisor low");
    rchk(0, 3'h1, 8'h34, "divisor high");
    chk("divisor port", 8'h34, baud_divisor[0][15:8]);
    wr(0, 3'h2, 8'h2b);
    chk("fraction locked", 8'h00, baud_div_fraction[0]);
    wr(0, 3'h0, 8'h00);
    wr(0, 3'h1, 8'h00);
    rchk(0, 3'h0, REV, "revision");
    rchk(0, 3'h1, IDC, "device id");
  endtask

  task automatic t_enh;
    wr(0, 3'h3, 8'hbf);
    wr(0, 3'h2, 8'hd0);
    wr(0, 3'h4, 8'h11);
    wr(0, 3'h7, 8'h44);
    rchk(0, 3'h2, 8'hd0, "enhanced");
    rchk(0, 3'h4, 8'h11, "flow on one");
    chk("flow off two", 8'h44, flow_chars[0][31:24]);
    wr(0, 3'h3, 8'h80);
    wr(0, 3'h2, 8'h2b);
    rchk(0, 3'h2, 8'h2b, "fraction");
    wr(0, 3'h3, 8'h00);
    wr(0, 3'h1, 8'hf3);
    rchk(0, 3'h1, 8'hf3, "intr enable");
    wr(0, 3'h4, 8'h44);
    chk_bit("ir enable", 1'b1, ir_enable[0]);
    chk_bit("ir invert", 1'b1, ir_invert[0]);
    wr(0, 3'h4, 8'h00);
  endtask

  task automatic t_loop;
    wr(0, 3'h4, 8'h13);
    chk_bit("loopback on", 1'b1, loopback[0]);
    chk_bit("rts pin held", 1'b1, rts_pin_n[0]);
    chk_bit("tx pin held", 1'b1, tx_pin[0]);
    chk("modem lines loop", 8'h03, {4'h0, modem_lines[0]});
    chk_bit("auto cts loop", 1'b0, auto_cts_enable[0]);
    @(posedge clk);
    tx_shift_out[0] <= 1'b0;
    @(posedge clk);
    tx_shift_out[0] <= 1'b1;
    #1;
    chk_bit("rx shift in", 1'b0, rx_shift_in[0]);
    wr(0, 3'h4, 8'h03);
    chk_bit("loopback off", 1'b0, loopback[0]);
    chk_bit("rts pin", 1'b0, rts_pin_n[0]);
    chk("modem lines pins", 8'h05, {4'h0, modem_lines[0]});
    chk_bit("auto cts", 1'b1, auto_cts_enable[0]);
  endtask

  initial begin
    rst          = 1'b1;
    rx_holding   = {8'h00, 8'h77};
    intr_status  = {8'h00, 8'hf1};
    line_status  = {8'h00, 8'h60};
    modem_status = {8'h00, 8'h0f};
    tx_shift_out = 2'b11;
    // Receive input kept high throughout, loopback included
    rx_pin       = 2'b11;
    cts_pin_n    = 2'b10;
    dsr_pin_n    = 2'b11;
    cd_pin_n     = 2'b11;
    ri_pin_n     = 2'b10;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_chan;
    t_hold;
    t_div;
    t_enh;
    t_loop;
    end_of_test;
  end

  // Whole run is near 460 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
